/* rtl/eedm_pkg.sv */
// Package of constants and types for the EEPROM data memory controller
package eedm_pkg;

    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;  // Control register
    localparam logic [7:0]  OFS_AUX         = 8'h04;  // Auxiliary control register
    localparam logic [7:0]  OFS_PTR         = 8'h08;  // Data pointer register
    localparam logic [7:0]  OFS_MOVE        = 8'h0C;  // External data move port

    // Control register field positions
    localparam int          CTRL_BUSY_BIT   = 0;      // Programming busy flag
    localparam int          CTRL_SEL_BIT    = 1;      // EEPROM space select
    localparam int          CTRL_CMD_LSB    = 4;      // Launch command field, low bit
    localparam int          AUX_STRETCH_BIT = 0;      // Move stretch bit

    // Reset values
    localparam logic [3:0]  CMD_RESET       = 4'h0;
    localparam logic [15:0] PTR_RESET       = 16'h0000;

    // Launch command nibbles
    localparam logic [3:0]  CMD_FIRST       = 4'h5;
    localparam logic [3:0]  CMD_SECOND      = 4'hA;

    // Memory geometry
    localparam int          PAGE_W          = 4;      // Page select bits of the pointer
    localparam int          COL_W           = 7;      // Byte-in-page bits of the pointer
    localparam int          PAGE_BYTES      = 128;    // Column latches per page
    localparam int          MEM_BYTES       = 1024;   // EEPROM and expanded RAM size
    localparam int          MEM_AW          = 10;     // Byte address width
    localparam logic [15:0] MEM_TOP         = 16'h03FF; // Last mapped address

    // Answer timing in clock cycles
    localparam logic [3:0]  WAIT_REG        = 4'h0;   // Register access wait states
    localparam logic [3:0]  WAIT_MOVE       = 4'h1;   // Plain move wait states
    localparam logic [3:0]  WAIT_STRETCH    = 4'h4;   // Stretched move wait states

    // Programming duration
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          PROG_TIME_NS    = 4000;
    localparam int          PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Control register image
    typedef struct packed {
        logic [3:0] cmd;       // Last launch command nibble
        logic [1:0] rsvd;      // Reads zero
        logic       spaceSel;  // EEPROM space select
        logic       busy;      // Programming busy flag
    } eedm_ctrl_s;

    // Register decode result
    typedef enum logic [2:0] {
        REG_CTRL,
        REG_AUX,
        REG_PTR,
        REG_MOVE,
        REG_NONE
    } eedm_reg_e;

    // Programming sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_PROG
    } eedm_state_e;

endpackage : eedm_pkg

/* rtl/eedm_launch_detect.sv */
// Two-write launch command detector for the control register
`timescale 1ns/1ns
module eedm_launch_detect (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       ctrlWr,    // Control register write taken
    input  wire logic [3:0] cmdNib,    // Upper nibble of the written byte
    output logic            launch     // Sequence complete, this cycle
);

    logic armed_r;  // First command nibble seen on previous control write

    // Any control write re-evaluates the arm state, so a stray write breaks the pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (ce && ctrlWr) begin
            armed_r <= (cmdNib == eedm_pkg::CMD_FIRST);
        end
    end

    // Only the upper nibble takes part in recognition
    assign launch = ce && ctrlWr && armed_r && (cmdNib == eedm_pkg::CMD_SECOND);

endmodule : eedm_launch_detect

/* rtl/eedm_column_latch.sv */
// Page column latches with per-byte written flags and page lock
`timescale 1ns/1ns
module eedm_column_latch #(
    parameter int COLS   = eedm_pkg::PAGE_BYTES,
    parameter int PAGE_W = eedm_pkg::PAGE_W,
    parameter int COL_W  = eedm_pkg::COL_W
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  wrEn,        // Latch write request
    input  wire logic [PAGE_W-1:0]     wrPage,      // Page of the write
    input  wire logic [COL_W-1:0]      wrCol,       // Byte within page
    input  wire logic [7:0]            wrData,      // Byte to latch
    input  wire logic                  clearAll,    // Row programmed, drop flags
    output logic [COLS-1:0][7:0]       latchData,   // Latched bytes
    output logic [COLS-1:0]            latchFlag,   // Ninth bits
    output logic [PAGE_W-1:0]          lockedPage,  // Page of first write
    output logic                       pageLocked   // A page is held
);

    logic accept;  // Write lands on the held page

    // Writes to another page than the first are discarded
    assign accept = wrEn && (!pageLocked || (wrPage == lockedPage));

    // Page capture on the first write after a programming run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pageLocked <= 1'b0;
            lockedPage <= '0;
        end else if (ce) begin
            if (clearAll) begin
                pageLocked <= 1'b0;
            end
            if (wrEn && !pageLocked) begin
                pageLocked <= 1'b1;
                lockedPage <= wrPage;
            end
        end
    end

    // One ninth bit per column; a write wins over the clear
    for (genvar c = 0; c < COLS; c++) begin : g_col
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                latchFlag[c] <= 1'b0;
            end else if (ce) begin
                if (clearAll) begin
                    latchFlag[c] <= 1'b0;
                end
                if (accept && (wrCol == COL_W'(c))) begin
                    latchFlag[c] <= 1'b1;
                end
            end
        end

        // Data bytes carry no reset; the flag says whether they count
        always_ff @(posedge clk) begin
            if (ce && accept && (wrCol == COL_W'(c))) begin
                latchData[c] <= wrData;
            end
        end
    end

endmodule : eedm_column_latch

/* rtl/eedm_ctrl.sv */
// EEPROM data memory controller top with APB register access
//
// Behaviour
// - EEPROM occupies 0000h-03FFh when space selected
// - Move read returns the addressed stored byte
// - Write is latch loading, then row programming
// - One to 128 latched bytes per run
// - Ninth flag per latch; only flagged bytes programmed
// - All ninth flags cleared after row programming
// - Pointer: upper bits page, low 7 byte
// - Move write stores byte into column latch
// - First page latched, other pages discarded
// - Writing 5x then Ax launches programming
// - Busy set; EEPROM reads refused while programming
// - Hardware clears busy when programming ends
// - Space select steers moves EEPROM or RAM
// - Software writes to busy flag ignored
// - Launch recognised from upper nibble only
// - Reset clears space select and busy
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
module eedm_ctrl #(
    parameter int PROG_CYCLES = eedm_pkg::PROG_CYCLES  // Row programming length
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,          // Freezes all state while low
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busyOut      // Programming busy flag
);

    localparam int PAGE_W = eedm_pkg::PAGE_W;
    localparam int COL_W  = eedm_pkg::COL_W;
    localparam int COLS   = eedm_pkg::PAGE_BYTES;
    localparam int AW     = eedm_pkg::MEM_AW;
    localparam int ROW_W  = AW - COL_W;

    // Register decode shared by the wait logic and the read path
    function automatic eedm_pkg::eedm_reg_e decodeReg(input logic [7:0] a);
        unique case (a)
            eedm_pkg::OFS_CTRL: decodeReg = eedm_pkg::REG_CTRL;
            eedm_pkg::OFS_AUX:  decodeReg = eedm_pkg::REG_AUX;
            eedm_pkg::OFS_PTR:  decodeReg = eedm_pkg::REG_PTR;
            eedm_pkg::OFS_MOVE: decodeReg = eedm_pkg::REG_MOVE;
            default:            decodeReg = eedm_pkg::REG_NONE;
        endcase
    endfunction : decodeReg

    // Software visible state
    eedm_pkg::eedm_ctrl_s   ctrl_r;       // Control register image
    logic                   stretch_r;    // Move stretch bit
    logic [15:0]            ptr_r;        // Data pointer

    // Bus answer state
    logic [3:0]             waitCnt_r;    // Wait states left in access phase
    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;

    // Programming sequencer
    eedm_pkg::eedm_state_e  state_r;
    logic [15:0]            progCnt_r;    // Cycles left in programming
    logic [PAGE_W-1:0]      progPage_r;   // Row being programmed
    logic                   progValid_r;  // Latches held a page at launch

    // Storage
    logic [7:0]             eeArray [eedm_pkg::MEM_BYTES];   // Nonvolatile cells
    logic [7:0]             ramArray [eedm_pkg::MEM_BYTES];  // Expanded RAM

    // Decoded request
    eedm_pkg::eedm_reg_e    reqReg;
    logic                   setup;        // Setup cycle of a transfer
    logic                   xfer;         // Edge at which transfer completes

    // Pointer split
    logic                   inRange;      // Pointer inside mapped window
    logic [AW-1:0]          memAddr;
    logic [PAGE_W-1:0]      ptrPage;
    logic [COL_W-1:0]       ptrCol;

    // Write strobes
    logic                   ctrlWr;
    logic                   moveWr;
    logic                   latchWr;
    logic                   ramWr;

    // Sequencer events
    logic                   launch;
    logic                   commit;       // Last programming cycle

    // Answer
    logic [3:0]             reqWait;
    logic [31:0]            rdValue;
    logic                   rdErr;

    // Column latch outputs
    logic [COLS-1:0][7:0]   latchData;
    logic [COLS-1:0]        latchFlag;
    logic [PAGE_W-1:0]      lockedPage;
    logic                   pageLocked;

    // Request decode
    assign reqReg  = decodeReg(paddr);
    assign setup   = psel && !penable;
    assign xfer    = ce && psel && penable && pready_r;

    // Only the low kilobyte answers as memory
    assign inRange = (ptr_r <= eedm_pkg::MEM_TOP);
    assign memAddr = ptr_r[AW-1:0];
    assign ptrPage = ptr_r[COL_W+PAGE_W-1:COL_W];
    assign ptrCol  = ptr_r[COL_W-1:0];

    assign ctrlWr  = xfer && pwrite && (reqReg == eedm_pkg::REG_CTRL);
    assign moveWr  = xfer && pwrite && (reqReg == eedm_pkg::REG_MOVE) && inRange;

    // Space select steers the move; latches are frozen during programming
    assign latchWr = moveWr && ctrl_r.spaceSel && !ctrl_r.busy;
    assign ramWr   = moveWr && !ctrl_r.spaceSel;

    assign commit  = (state_r == eedm_pkg::ST_PROG) && (progCnt_r == 16'h0000);

    // Moves are slow; the stretch bit lengthens them further
    always_comb begin
        if (reqReg != eedm_pkg::REG_MOVE) begin
            reqWait = eedm_pkg::WAIT_REG;
        end else if (stretch_r) begin
            reqWait = eedm_pkg::WAIT_STRETCH;
        end else begin
            reqWait = eedm_pkg::WAIT_MOVE;
        end
    end

    // Read value and error for the current request
    always_comb begin
        rdValue = 32'h0000_0000;
        rdErr   = 1'b0;

        unique case (reqReg)
            eedm_pkg::REG_CTRL: begin
                rdValue[7:0] = ctrl_r;
            end

            eedm_pkg::REG_AUX: begin
                rdValue[eedm_pkg::AUX_STRETCH_BIT] = stretch_r;
            end

            eedm_pkg::REG_PTR: begin
                rdValue[15:0] = ptr_r;
            end

            eedm_pkg::REG_MOVE: begin
                if (!inRange) begin
                    rdValue = 32'h0000_0000;  // Unmapped pointer reads zero
                end else if (ctrl_r.spaceSel) begin
                    if (ctrl_r.busy) begin
                        rdErr = 1'b1;
                    end else begin
                        rdValue[7:0] = eeArray[memAddr];
                    end
                end else begin
                    rdValue[7:0] = ramArray[memAddr];
                end
            end

            eedm_pkg::REG_NONE: begin
                rdErr = 1'b1;  // Unmapped offset
            end
        endcase
        // Writes carry no data
        if (pwrite) begin
            rdValue = 32'h0000_0000;
            rdErr   = (reqReg == eedm_pkg::REG_NONE);
        end
    end

    // APB answer: pready raised after the wait states, held one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_r <= 4'h0;
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r <= 1'b0;

            if (setup) begin
                // Zero-wait offsets answer at once
                waitCnt_r <= reqWait;
                if (reqWait == 4'h0) begin
                    pready_r  <= 1'b1;
                    prdata_r  <= rdValue;
                    pslverr_r <= rdErr;
                end
            end else if (psel && penable && !pready_r && (waitCnt_r != 4'h0)) begin
                // Count the access phase down
                waitCnt_r <= waitCnt_r - 4'h1;
                if (waitCnt_r == 4'h1) begin
                    pready_r  <= 1'b1;
                    prdata_r  <= rdValue;
                    pslverr_r <= rdErr;
                end
            end else if (!psel) begin
                // Idle bus shows no data
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0000_0000;
            end
        end
    end

    // Control register in one process; busy is moved by the sequencer only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r.cmd      <= eedm_pkg::CMD_RESET;
            ctrl_r.rsvd     <= 2'b00;
            ctrl_r.spaceSel <= 1'b0;
            ctrl_r.busy     <= 1'b0;
        end else if (ce) begin
            if (ctrlWr) begin
                ctrl_r.cmd      <= pwdata[eedm_pkg::CTRL_CMD_LSB +: 4];
                ctrl_r.spaceSel <= pwdata[eedm_pkg::CTRL_SEL_BIT];
            end

            // Bus writes never reach busy
            if (launch && !ctrl_r.busy) begin
                ctrl_r.busy <= 1'b1;
            end else if (commit) begin
                ctrl_r.busy <= 1'b0;
            end
        end
    end

    // Auxiliary control and pointer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_r <= 1'b0;
            ptr_r     <= eedm_pkg::PTR_RESET;
        end else if (ce && xfer && pwrite) begin
            if (reqReg == eedm_pkg::REG_AUX) begin
                stretch_r <= pwdata[eedm_pkg::AUX_STRETCH_BIT];
            end

            if (reqReg == eedm_pkg::REG_PTR) begin
                // Only the low 10 bits address memory
                ptr_r <= pwdata[15:0];
            end
        end
    end

    // Launch command recogniser
    eedm_launch_detect u_launch (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .ctrlWr (ctrlWr),
        .cmdNib (pwdata[eedm_pkg::CTRL_CMD_LSB +: 4]),
        .launch (launch)
    );

    // Column latches, first phase of a write
    eedm_column_latch #(
        .COLS   (COLS),
        .PAGE_W (PAGE_W),
        .COL_W  (COL_W)
    ) u_latch (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .wrEn       (latchWr),
        .wrPage     (ptrPage),
        .wrCol      (ptrCol),
        .wrData     (pwdata[7:0]),
        .clearAll   (commit),
        .latchData  (latchData),
        .latchFlag  (latchFlag),
        .lockedPage (lockedPage),
        .pageLocked (pageLocked)
    );

    // Programming sequencer: idle until launch, count, then commit the row
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= eedm_pkg::ST_IDLE;
            progCnt_r   <= 16'h0000;
            progPage_r  <= '0;
            progValid_r <= 1'b0;
        end else if (ce) begin
            unique case (state_r)
                eedm_pkg::ST_IDLE: begin
                    // Page frozen for the whole run
                    if (launch) begin
                        state_r     <= eedm_pkg::ST_PROG;
                        progCnt_r   <= 16'(PROG_CYCLES - 1);
                        progPage_r  <= lockedPage;
                        progValid_r <= pageLocked;
                    end
                end

                eedm_pkg::ST_PROG: begin
                    if (progCnt_r == 16'h0000) begin
                        state_r <= eedm_pkg::ST_IDLE;
                    end else begin
                        progCnt_r <= progCnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Row transfer: only flagged columns overwrite cells
    always_ff @(posedge clk) begin
        if (ce && commit && progValid_r) begin
            for (int c = 0; c < COLS; c++) begin
                // Unflagged columns keep old cells
                if (latchFlag[c]) begin
                    eeArray[{progPage_r[ROW_W-1:0], COL_W'(c)}] <= latchData[c];
                end
            end
        end
    end

    // Expanded RAM write path
    always_ff @(posedge clk) begin
        if (ce && ramWr) begin
            ramArray[memAddr] <= pwdata[7:0];
        end
    end

    // Outputs straight from flops
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign busyOut = ctrl_r.busy;

endmodule : eedm_ctrl

/* verification/eedm_ctrl_sva.sv */
// Port-level assertion checker for the EEPROM data memory controller
`timescale 1ns/1ns
module eedm_ctrl_sva #(
    parameter int PROG_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busyOut
);
    logic ctrlDone;  // Completed control write
    logic auxDone;   // Completed aux write
    logic armedR;    // First launch nibble seen
    logic selR;      // Shadow of space select
    logic strR;      // Shadow of stretch bit
    int   busyCnt;   // Cycles spent busy
    assign ctrlDone = psel && penable && pready && pwrite && (paddr == eedm_pkg::OFS_CTRL);
    assign auxDone  = psel && penable && pready && pwrite && (paddr == eedm_pkg::OFS_AUX);
    // Shadow state; any other control write breaks the pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armedR  <= 1'b0;
            selR    <= 1'b0;
            strR    <= 1'b0;
            busyCnt <= 0;
        end else if (ce) begin
            if (ctrlDone) begin
                armedR <= (pwdata[7:4] == eedm_pkg::CMD_FIRST);
                selR   <= pwdata[1];
            end
            if (auxDone) begin
                strR <= pwdata[0];
            end
            busyCnt <= busyOut ? busyCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    launch_start_a: assert property (ctrlDone && ce && armedR && !busyOut
        && pwdata[7:4] == eedm_pkg::CMD_SECOND |=> busyOut) else $error("launch missed");
    busy_cause_a: assert property ($rose(busyOut) |->
        $past(ctrlDone && armedR && pwdata[7:4] == eedm_pkg::CMD_SECOND)) else $error("stray busy");
    busy_length_a: assert property ($fell(busyOut) |-> busyCnt == PROG_CYCLES)
        else $error("busy length wrong");
    busy_bound_a: assert property (busyCnt <= PROG_CYCLES) else $error("busy overran");
    busy_read_a: assert property (psel && penable && pready && !pwrite && selR && busyOut
        && paddr == eedm_pkg::OFS_MOVE |-> pslverr && prdata == 32'h0000_0000)
        else $error("read during busy not refused");
    busy_ro_a: assert property (ctrlDone && ce && !busyOut
        && !(armedR && pwdata[7:4] == eedm_pkg::CMD_SECOND) |=> !busyOut)
        else $error("software set busy");
    stretch_wait_a: assert property (psel && !penable && ce && strR
        && paddr == eedm_pkg::OFS_MOVE |=> !pready [*4] ##1 pready) else $error("stretch wait");
    move_wait_a: assert property (psel && !penable && ce && !strR
        && paddr == eedm_pkg::OFS_MOVE |=> !pready ##1 pready) else $error("move wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    cover property (ctrlDone && armedR && pwdata[7:4] == eedm_pkg::CMD_SECOND);
    cover property ($fell(busyOut));
    cover property (psel && penable && pready && pslverr);
endmodule : eedm_ctrl_sva

bind eedm_ctrl eedm_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) eedm_ctrl_sva_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busyOut(busyOut));

/* verification/eedm_core_model.sv */
// Core-side APB master model issuing register and data move transfers
`timescale 1ns/1ns
module eedm_core_model (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic             hung      // Answer never came
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'hFF;
        pwdata  = 32'hFFFF_FFFF;
        hung    = 1'b0;
    end
    // One transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            hung <= 1'b1;
        end
        rd = prdata;
        er = pslverr;
        // Released address and data lines show the inverse, never a stale value
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : eedm_core_model

/* verification/eedm_ctrl_tb.sv */
// Self-checking testbench for the EEPROM data memory controller
`timescale 1ns/1ns
module eedm_ctrl_tb;
    localparam int PROG = 16;  // Short programming time for simulation
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busyOut;
    logic        hung;
    int          failures;
    int          compares;
    logic [15:0] ptrs [5] = '{16'h0105, 16'h0106, 16'h0085, 16'h0086, 16'h00FF};
    logic [7:0]  vals [5] = '{8'h99, 8'h20, 8'hA5, 8'h5A, 8'hC3};
    eedm_ctrl #(.PROG_CYCLES(PROG)) eedm_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busyOut(busyOut));
    eedm_core_model eedm_core_model_inst (
        .clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));
    // Free-running clock, 8 ns period
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // Verdict and end of run
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    // Compare; an unknown expectation skips the data
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        if (!$isunknown(e)) begin
            compares++;
            if (g !== e) begin
                failures++;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        er;
        eedm_core_model_inst.xfer(1'b1, a, d, r, er);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic ee);
        logic [31:0] r;
        logic        er;
        eedm_core_model_inst.xfer(1'b0, a, 32'h0000_0000, r, er);
        chk(nm, e, r);
        chk({nm, " error"}, {31'h0000_0000, ee}, {31'h0000_0000, er});
    endtask : rd
    // Pointer load then byte move
    task automatic mv(input logic [15:0] p, input logic [7:0] d);
        wr(eedm_pkg::OFS_PTR, {16'h0000, p});
        wr(eedm_pkg::OFS_MOVE, {24'h00_0000, d});
    endtask : mv
    task automatic mr(input string nm, input logic [15:0] p, input logic [7:0] e);
        wr(eedm_pkg::OFS_PTR, {16'h0000, p});
        rd(nm, eedm_pkg::OFS_MOVE, {24'h00_0000, e}, 1'b0);
    endtask : mr
    // Launch pair, optional aux access between, then wait out busy
    task automatic launch(input logic [7:0] first, input logic mid);
        int n;
        wr(eedm_pkg::OFS_CTRL, {24'h00_0000, first});
        if (mid) wr(eedm_pkg::OFS_AUX, 32'h0000_0001);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_00A2);
        rd("ctrl busy", eedm_pkg::OFS_CTRL, 32'h0000_00A3, 1'b0);
        rd("move busy", eedm_pkg::OFS_MOVE, 32'h0000_0000, 1'b1);
        n = 0;
        while (busyOut !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            failures++;
            close_out();
        end
        rd("ctrl done", eedm_pkg::OFS_CTRL, 32'h0000_00A2, 1'b0);
    endtask : launch
    // A hung transfer ends the run
    always @(posedge clk) begin
        if (hung === 1'b1) begin
            failures++;
            close_out();
        end
    end
    // Main sequence
    initial begin
        rst_n    = 1'b0;
        ce       = 1'b1;
        failures = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl reset", eedm_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
        chk("busy reset", 32'h0000_0000, {31'h0000_0000, busyOut});
        rd("unmapped", 8'h10, 32'hxxxx_xxxx, 1'b1);
        mv(16'h0105, 8'h44);
        mr("ram byte", 16'h0105, 8'h44);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_0003);
        rd("busy write", eedm_pkg::OFS_CTRL, 32'h0000_0002, 1'b0);
        wr(eedm_pkg::OFS_AUX, 32'h0000_0001);
        mv(16'h0105, 8'h10);
        mv(16'h0106, 8'h20);
        launch(8'h52, 1'b1);
        mv(16'h0085, 8'hA5);
        mv(16'h0086, 8'h5A);
        mv(16'h0106, 8'hEE);
        mv(16'h00FF, 8'hC3);
        launch(8'h53, 1'b0);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_0052);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_0002);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_00A2);
        repeat (3) @(posedge clk);
        chk("broken pair", 32'h0000_0000, {31'h0000_0000, busyOut});
        mv(16'h0105, 8'h99);
        launch(8'h52, 1'b0);
        for (int i = 0; i < 5; i++) begin
            mr("eeprom byte", ptrs[i], vals[i]);
        end
        mv(16'h0400, 8'h77);
        mr("beyond top", 16'h0400, 8'h00);
        wr(eedm_pkg::OFS_CTRL, 32'h0000_0000);
        mr("ram kept", 16'h0105, 8'h44);
        close_out();
    end
endmodule : eedm_ctrl_tb
